// file: hw/ass_supply_switch.sv
`timescale 1ns/1ps
// Contract
// - An auxiliary source always feeds both the analog and the digital system rail together.
// - The source is chosen either by software command or automatically by hardware thresholds.
// - A source change never stops or resets the running logic.
// - After power-up the start source is primary or backup one, whichever is higher.
// - A software priority bit decides whether backup two is tried before backup one.
// - In hardware mode a supervisor drop moves to another source that is marked valid.
// - In hardware mode, each source neither in use nor under software control is checked by the comparator.
// - Each checked source uses its own threshold code and its result becomes its valid flag.
// - With no source left to check, automatic checking is switched off.
// - A valid backup source never starts a switch by itself, only a supervisor drop does.
// - A valid primary source is switched back to at once without a supervisor drop.
// - Two checked sources share the comparator, alternating one per oscillator period.
// - Threshold codes 0 to 7 are shared by backup and supervisor levels, 6 and 7 equal.
module ass_supply_switch #(
  parameter int VLO_CYCLES = ass_pkg::VLO_CYCLES
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // AHB-Lite slave
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic      [31:0]                 hrdata,
  output logic                             hreadyout,
  output logic                             hresp,
  // Analog comparators and supervisor
  input  wire logic                        primary_above_backup,
  input  wire logic                        supervisor_below,
  input  wire logic                        comparator_above,
  // Switch and monitor controls
  output ass_pkg::ass_rail_s               rail_sel,
  output ass_pkg::ass_cmp_s                monitor,
  output logic [ass_pkg::LVL_W-1:0]        supervisor_level_field
);

  logic                             acc_q;
  logic                             wr_q;
  logic [ass_pkg::ADDR_W-1:0]       addr_q;
  logic [31:0]                      rdata_q;
  logic [31:0]                      ctrl_q;
  logic [31:0]                      level_q;
  logic [31:0]                      rd_val;
  logic                             take;
  ass_pkg::ass_state_e              state_q;
  logic [ass_pkg::SRC_W-1:0]        active_q;
  logic [ass_pkg::SRC_W-1:0]        active_d;
  logic                             svm_switch;
  logic [ass_pkg::NUM_SRC-1:0]      valid_q;
  logic [ass_pkg::NUM_SRC-1:0]      mon_mask;
  logic [ass_pkg::NUM_SRC-1:0]      cand;
  logic                             sw_mode;
  logic [ass_pkg::SRC_W-1:0]        sw_sel;
  logic                             prio_b2;
  logic [ass_pkg::NUM_SRC-1:0]      swctl;
  logic                             tick;
  logic                             sched_en;
  logic [ass_pkg::SRC_W-1:0]        sched_src;
  ass_pkg::ass_cmp_s                mon_q;
  logic [ass_pkg::LVL_W-1:0]        svm_lvl_q;

  // Codes 6 and 7 name one level, so the analog side only ever sees 6
  function automatic logic [ass_pkg::LVL_W-1:0] merge_code(input logic [ass_pkg::LVL_W-1:0] c);
    return (c == ass_pkg::LVL_TOP) ? ass_pkg::LVL_MERGED : c;
  endfunction : merge_code

  function automatic logic [ass_pkg::LVL_W-1:0] src_code(
    input logic [31:0]               lv,
    input logic [ass_pkg::SRC_W-1:0] s
  );
    logic [ass_pkg::LVL_W-1:0] c;
    c = lv[ass_pkg::LVL_PRI_LSB +: ass_pkg::LVL_W];
    if (s == ass_pkg::SRC_B1) begin
      c = lv[ass_pkg::LVL_B1_LSB +: ass_pkg::LVL_W];
    end else if (s == ass_pkg::SRC_B2) begin
      c = lv[ass_pkg::LVL_B2_LSB +: ass_pkg::LVL_W];
    end
    return merge_code(c);
  endfunction : src_code

  // Bus slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;
  assign take      = hsel && hready && htrans[1];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_q  <= 1'b0;
      wr_q   <= 1'b0;
      addr_q <= '0;
    end else if (hready) begin
      acc_q  <= take;
      wr_q   <= hwrite;
      addr_q <= haddr[ass_pkg::ADDR_W-1:0];
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    if (haddr[ass_pkg::ADDR_W-1:0] == ass_pkg::ADDR_CTRL) begin
      rd_val = ctrl_q;
    end else if (haddr[ass_pkg::ADDR_W-1:0] == ass_pkg::ADDR_LEVEL) begin
      rd_val = level_q;
    end else if (haddr[ass_pkg::ADDR_W-1:0] == ass_pkg::ADDR_STATUS) begin
      rd_val[ass_pkg::ST_ACTIVE_LSB +: ass_pkg::SRC_W]  = active_q;
      rd_val[ass_pkg::ST_VALID_LSB +: ass_pkg::NUM_SRC] = valid_q;
      rd_val[ass_pkg::ST_MON_LSB +: ass_pkg::NUM_SRC]   = mon_mask;
      rd_val[ass_pkg::ST_CMP_LSB +: ass_pkg::SRC_W]     = sched_src;
      rd_val[ass_pkg::ST_RUN]                           = (state_q == ass_pkg::ST_RUNNING);
    end
  end

  // Read data are captured in the address phase, one cycle ahead of the data phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      rdata_q <= rd_val;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q  <= ass_pkg::CTRL_RESET;
      level_q <= ass_pkg::LEVEL_RESET;
    end else if (acc_q && wr_q) begin
      if (addr_q == ass_pkg::ADDR_CTRL) begin
        ctrl_q <= hwdata & ass_pkg::CTRL_MASK;
      end else if (addr_q == ass_pkg::ADDR_LEVEL) begin
        level_q <= hwdata & ass_pkg::LEVEL_MASK;
      end
    end
  end

  assign sw_mode = ctrl_q[ass_pkg::CTRL_SW_MODE];
  assign sw_sel  = ctrl_q[ass_pkg::CTRL_SEL_LSB +: ass_pkg::SRC_W];
  assign prio_b2 = ctrl_q[ass_pkg::CTRL_PRIO];
  assign swctl   = ctrl_q[ass_pkg::CTRL_SWCTL_LSB +: ass_pkg::NUM_SRC];

  generate
    for (genvar i = 0; i < ass_pkg::NUM_SRC; i++) begin : g_mask
      assign mon_mask[i] = !sw_mode && !swctl[i] && (active_q != ass_pkg::SRC_W'(i));
      assign cand[i]     = mon_mask[i] && valid_q[i];
    end
  endgenerate

  ass_mon_sched #(
    .DIV (VLO_CYCLES),
    .N   (ass_pkg::NUM_SRC)
  ) u_sched (
    .clk  (clk),
    .rst  (rst),
    .mask (mon_mask),
    .tick (tick),
    .en   (sched_en),
    .src  (sched_src)
  );

  always_comb begin
    active_d   = active_q;
    svm_switch = 1'b0;
    if (state_q == ass_pkg::ST_BOOT) begin
      active_d = primary_above_backup ? ass_pkg::SRC_PRI : ass_pkg::SRC_B1;
    end else if (sw_mode) begin
      if (sw_sel != ass_pkg::SRC_NONE) begin
        active_d = sw_sel;
      end
    end else if (cand[ass_pkg::SRC_PRI]) begin
      active_d = ass_pkg::SRC_PRI;
    end else if (supervisor_below) begin
      if (cand[ass_pkg::SRC_B1] && cand[ass_pkg::SRC_B2]) begin
        active_d = prio_b2 ? ass_pkg::SRC_B2 : ass_pkg::SRC_B1;
      end else if (cand[ass_pkg::SRC_B1]) begin
        active_d = ass_pkg::SRC_B1;
      end else if (cand[ass_pkg::SRC_B2]) begin
        active_d = ass_pkg::SRC_B2;
      end
      svm_switch = (active_d != active_q);
    end
  end

  // glitch free change, only the select moves
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q  <= ass_pkg::ST_BOOT;
      active_q <= ass_pkg::SRC_PRI;
    end else begin
      state_q  <= ass_pkg::ST_RUNNING;
      active_q <= active_d;
    end
  end

  // flag at period end
  // The abandoned source is marked bad so a stale flag cannot pull the rail straight back
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      valid_q <= '0;
    end else begin
      if (svm_switch) begin
        valid_q[active_q] <= 1'b0;
      end
      if (tick) begin
        valid_q[sched_src] <= comparator_above;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mon_q     <= '0;
      svm_lvl_q <= '0;
    end else begin
      mon_q.en   <= sched_en;
      mon_q.src  <= sched_src;
      mon_q.code <= src_code(level_q, sched_src);
      svm_lvl_q  <= merge_code(level_q[ass_pkg::LVL_SVM_LSB +: ass_pkg::LVL_W]);
    end
  end

  assign rail_sel.analog_sel  = active_q;
  assign rail_sel.digital_sel = active_q;
  assign monitor                = mon_q;
  assign supervisor_level_field = svm_lvl_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_hw_run;
    state_q == ass_pkg::ST_RUNNING && !sw_mode;
  endsequence

  sequence s_two_tick;
    tick && (mon_mask == 3'b011 || mon_mask == 3'b101 || mon_mask == 3'b110);
  endsequence

  a_rails_same: assert property (rail_sel.analog_sel == rail_sel.digital_sel)
    else $error("rails fed from different sources");
  a_boot_pick: assert property (state_q == ass_pkg::ST_BOOT |=>
      active_q == ($past(primary_above_backup) ? ass_pkg::SRC_PRI : ass_pkg::SRC_B1))
    else $error("wrong start source");
  a_sw_select: assert property (state_q == ass_pkg::ST_RUNNING && sw_mode
      && sw_sel != ass_pkg::SRC_NONE |=> active_q == $past(sw_sel))
    else $error("software selection not applied");
  a_pri_return: assert property (s_hw_run and cand[ass_pkg::SRC_PRI]
      |=> active_q == ass_pkg::SRC_PRI)
    else $error("valid primary not taken back");
  a_no_self_switch: assert property (s_hw_run and !supervisor_below
      && !cand[ass_pkg::SRC_PRI] |=> $stable(active_q))
    else $error("source changed without supervisor drop");
  a_drop_switch: assert property (s_hw_run and supervisor_below && (cand != '0)
      |=> active_q != $past(active_q) && (($past(cand) >> active_q) & 3'b001) == 3'b001)
    else $error("drop did not move to a valid source");
  a_prio_pick: assert property (s_hw_run and supervisor_below
      && !cand[ass_pkg::SRC_PRI] && cand[ass_pkg::SRC_B1] && cand[ass_pkg::SRC_B2]
      |=> active_q == ($past(prio_b2) ? ass_pkg::SRC_B2 : ass_pkg::SRC_B1))
    else $error("priority ignored");
  a_none_keep: assert property (s_hw_run and supervisor_below && cand == '0
      |=> $stable(active_q))
    else $error("source left with no valid alternative");
  a_mon_off: assert property (mon_mask == '0 |=> !sched_en ##1 !monitor.en)
    else $error("checking not switched off");
  a_mon_target: assert property (tick |-> mon_mask[sched_src]
      && monitor.en && monitor.src == sched_src)
    else $error("comparator on a source not to be checked");
  a_valid_hold: assert property (!tick && !svm_switch |=> $stable(valid_q))
    else $error("valid flag changed mid period");
  a_flag_load: assert property (tick |=> valid_q[$past(sched_src)]
      == $past(comparator_above))
    else $error("result not stored in own flag");
  a_alternate: assert property (s_two_tick ##1 $stable(mon_mask)
      |-> sched_src != $past(sched_src))
    else $error("sources did not alternate");
  a_level_merge: assert property (supervisor_level_field != ass_pkg::LVL_TOP
      && monitor.code != ass_pkg::LVL_TOP)
    else $error("unmerged top code reached analog side");
  a_no_stall: assert property (hreadyout && !hresp)
    else $error("bus stalled across switchover");

endmodule : ass_supply_switch

// file: inc/ass_pkg.sv
package ass_pkg;

  // Clock and oscillator timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int VLO_PERIOD_US = 100;
  localparam int VLO_CYCLES    = (VLO_PERIOD_US * 1000) / CLK_PERIOD_NS;

  // Supply sources
  localparam int             NUM_SRC  = 3;
  localparam int             SRC_W    = 2;
  localparam logic [SRC_W-1:0] SRC_PRI  = 2'h0;
  localparam logic [SRC_W-1:0] SRC_B1   = 2'h1;
  localparam logic [SRC_W-1:0] SRC_B2   = 2'h2;
  localparam logic [SRC_W-1:0] SRC_NONE = 2'h3;

  // Threshold codes
  localparam int             LVL_W      = 3;
  localparam logic [LVL_W-1:0] LVL_TOP    = 3'h7;
  localparam logic [LVL_W-1:0] LVL_MERGED = 3'h6;

  // Register byte addresses
  localparam int             ADDR_W      = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_LEVEL  = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;

  // Control register fields
  localparam int          CTRL_SW_MODE   = 0;
  localparam int          CTRL_SEL_LSB   = 1;
  localparam int          CTRL_PRIO      = 3;
  localparam int          CTRL_SWCTL_LSB = 4;
  localparam logic [31:0] CTRL_MASK      = 32'h0000_007f;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

  // Level register fields
  localparam int          LVL_PRI_LSB = 0;
  localparam int          LVL_B1_LSB  = 4;
  localparam int          LVL_B2_LSB  = 8;
  localparam int          LVL_SVM_LSB = 12;
  localparam logic [31:0] LEVEL_MASK  = 32'h0000_7777;
  localparam logic [31:0] LEVEL_RESET = 32'h0000_0000;

  // Status register fields
  localparam int ST_ACTIVE_LSB = 0;
  localparam int ST_VALID_LSB  = 4;
  localparam int ST_MON_LSB    = 8;
  localparam int ST_CMP_LSB    = 12;
  localparam int ST_RUN        = 16;

  typedef enum {ST_BOOT, ST_RUNNING} ass_state_e;

  typedef struct packed {
    logic [SRC_W-1:0] analog_sel;
    logic [SRC_W-1:0] digital_sel;
  } ass_rail_s;

  typedef struct packed {
    logic             en;
    logic [SRC_W-1:0] src;
    logic [LVL_W-1:0] code;
  } ass_cmp_s;

endpackage : ass_pkg

// file: hw/ass_mon_sched.sv
`timescale 1ns/1ps
module ass_mon_sched #(
  parameter int DIV = ass_pkg::VLO_CYCLES,
  parameter int N   = ass_pkg::NUM_SRC
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // Sources to be checked
  input  wire logic [N-1:0]             mask,
  // Schedule
  output logic                          tick,
  output logic                          en,
  output logic [ass_pkg::SRC_W-1:0]     src
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  logic [CW-1:0]                 cnt_q;
  logic [ass_pkg::SRC_W-1:0]     src_q;
  logic                          en_q;

  // Next monitored source after cur, wrapping round; cur itself if it is the only one
  function automatic logic [ass_pkg::SRC_W-1:0] next_src(
    input logic [ass_pkg::SRC_W-1:0] cur,
    input logic [N-1:0]              m
  );
    logic [ass_pkg::SRC_W-1:0] res;
    logic                      found;
    int                        idx;
    res   = cur;
    found = 1'b0;
    for (int k = 1; k <= N; k++) begin
      idx = (int'(cur) + k) % N;
      if (!found && m[idx]) begin
        res   = ass_pkg::SRC_W'(idx);
        found = 1'b1;
      end
    end
    return res;
  endfunction : next_src

  assign tick = en_q && mask[src_q] && (cnt_q == CW'(DIV - 1));
  assign en   = en_q;
  assign src  = src_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      src_q <= ass_pkg::SRC_PRI;
      en_q  <= 1'b0;
    end else if (mask == '0) begin
      cnt_q <= '0;
      en_q  <= 1'b0;
    end else if (!en_q || !mask[src_q]) begin
      // Set changed under us: restart a full period on a legal source
      src_q <= next_src(src_q, mask);
      en_q  <= 1'b1;
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= '0;
      src_q <= next_src(src_q, mask);
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

endmodule : ass_mon_sched

// file: verif/ass_analog_model.sv
`timescale 1ns/1ps
module ass_analog_model (
  // Clock
  input  wire logic                      clk,
  // Source voltages, in threshold-code units
  input  wire logic [3:0]                v_pri,
  input  wire logic [3:0]                v_b1,
  input  wire logic [3:0]                v_b2,
  // Controls from the switch
  input  wire ass_pkg::ass_rail_s        rail_sel,
  input  wire ass_pkg::ass_cmp_s         monitor,
  input  wire logic [ass_pkg::LVL_W-1:0] supervisor_level_field,
  // Analog results
  output logic                           primary_above_backup,
  output logic                           supervisor_below,
  output logic                           comparator_above
);
  logic [3:0] v [4];
  logic       junk_q = 1'b0;

  assign v[0] = v_pri;
  assign v[1] = v_b1;
  assign v[2] = v_b2;
  assign v[3] = 4'h0;
  // Idle comparator output wanders, so a stale result never looks settled
  always @(posedge clk) junk_q <= ~junk_q;
  assign primary_above_backup = v_pri > v_b1;
  assign supervisor_below = v[rail_sel.digital_sel] < {1'b0, supervisor_level_field};
  assign comparator_above = monitor.en ? (v[monitor.src] > {1'b0, monitor.code}) : junk_q;
endmodule : ass_analog_model

// file: verif/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int          VC   = 8;
  localparam logic [31:0] FULL = 32'hffff_ffff;
  logic                               clk, rst, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0]                        haddr, hwdata, hrdata;
  logic [1:0]                         htrans;
  logic [2:0]                         hsize;
  logic [3:0]                         vp, v1, v2;
  logic                               pab, sbl, cab;
  ass_pkg::ass_rail_s                 rail_sel;
  ass_pkg::ass_cmp_s                  monitor;
  logic [ass_pkg::LVL_W-1:0]          sup_lvl;
  int                                 err_count = 0;
  int                                 cmp_count = 0;
  int                                 cyc = 0;

  ass_supply_switch #(.VLO_CYCLES(VC)) DUT (.clk(clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .primary_above_backup(pab), .supervisor_below(sbl), .comparator_above(cab),
    .rail_sel(rail_sel), .monitor(monitor), .supervisor_level_field(sup_lvl));
  ass_analog_model PART (.clk(clk), .v_pri(vp), .v_b1(v1), .v_b2(v2),
    .rail_sel(rail_sel), .monitor(monitor), .supervisor_level_field(sup_lvl),
    .primary_above_backup(pab), .supervisor_below(sbl), .comparator_above(cab));
  assign hready = hreadyout;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(n, exp, q & m);
    chk("resp", 32'h0000_0000, {31'h0000_0000, hresp});
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  // Polls up to n edges for the rails to reach source s
  task automatic rail_is(input logic [1:0] s, input int n);
    int k;
    k = 0;
    while (rail_sel !== {s, s} && k < n) begin
      @(posedge clk);
      k++;
    end
    chk("rail", {28'h000_0000, s, s}, {28'h000_0000, rail_sel});
  endtask : rail_is

  // Collects which sources the comparator visits and checks their codes
  task automatic watch(input int n, input logic [2:0] exp_m, input logic [8:0] codes);
    logic [2:0] seen;
    int         bad;
    seen = 3'h0;
    bad  = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (monitor.en === 1'b1) begin
        seen[monitor.src] = 1'b1;
        if (monitor.code !== codes[3*monitor.src +: 3]) bad++;
      end
    end
    @(posedge clk);
    chk("monitored", {29'h0000_0000, exp_m}, {29'h0000_0000, seen});
    chk("code", 32'h0000_0000, bad);
  endtask : watch

  task automatic done(input string n);
    $display("test %s done", n);
  endtask : done

  initial begin
    rst    = 1'b1;
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
    vp     = 4'h5;
    v1     = 4'h4;
    v2     = 4'h7;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rail_is(2'h0, 4);
    rd("ctrl", ass_pkg::ADDR_CTRL, FULL, 32'h0000_0000);
    rd("level", ass_pkg::ADDR_LEVEL, FULL, 32'h0000_0000);
    rd("unmapped", 8'h0c, FULL, 32'h0000_0000);
    rd("status", ass_pkg::ADDR_STATUS, 32'h0001_0703, 32'h0001_0600);
    done("defaults");
    wr(ass_pkg::ADDR_LEVEL, 32'h0000_4723);
    rd("level", ass_pkg::ADDR_LEVEL, FULL, 32'h0000_4723);
    chk("sup level", 32'h0000_0004, {29'h0000_0000, sup_lvl});
    watch(4 * VC, 3'h6, {3'h6, 3'h2, 3'h3});
    rd("valid", ass_pkg::ADDR_STATUS, 32'h0000_0070, 32'h0000_0060);
    rail_is(2'h0, 0);
    done("monitor");
    vp <= 4'h3;
    rail_is(2'h1, 8);
    watch(4 * VC, 3'h5, {3'h6, 3'h2, 3'h3});
    rail_is(2'h1, 0);
    rd("running", ass_pkg::ADDR_STATUS, 32'h0001_0003, 32'h0001_0001);
    vp <= 4'h5;
    rail_is(2'h0, 4 * VC);
    done("drop");
    wr(ass_pkg::ADDR_CTRL, 32'h0000_0008);
    watch(4 * VC, 3'h6, {3'h6, 3'h2, 3'h3});
    vp <= 4'h3;
    rail_is(2'h2, 8);
    vp <= 4'h5;
    rail_is(2'h0, 4 * VC);
    done("priority");
    wr(ass_pkg::ADDR_CTRL, 32'h0000_0068);
    idle(4);
    watch(2 * VC, 3'h0, 9'h000);
    vp <= 4'h3;
    idle(8);
    rail_is(2'h0, 0);
    vp <= 4'h5;
    done("no candidate");
    wr(ass_pkg::ADDR_CTRL, 32'h0000_0005);
    rail_is(2'h2, 4);
    idle(4);
    watch(2 * VC, 3'h0, 9'h000);
    wr(ass_pkg::ADDR_CTRL, 32'h0000_0003);
    rail_is(2'h1, 4);
    wr(ass_pkg::ADDR_CTRL, 32'h0000_0007);
    idle(2);
    rail_is(2'h1, 0);
    rd("running", ass_pkg::ADDR_STATUS, 32'h0001_0000, 32'h0001_0000);
    done("software");
    wr(ass_pkg::ADDR_LEVEL, FULL);
    rd("level", ass_pkg::ADDR_LEVEL, FULL, 32'h0000_7777);
    chk("sup level", 32'h0000_0006, {29'h0000_0000, sup_lvl});
    done("codes");
    vp  <= 4'h3;
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    rail_is(2'h1, 4);
    rd("ctrl", ass_pkg::ADDR_CTRL, FULL, 32'h0000_0000);
    done("second reset");
    print_verdict();
  end
endmodule : tb
